// File: core/msb_pkg.sv
// Shared constants and types for the multidrop scan bridge control block.
package msb_pkg;
  localparam int IR_W     = 8;
  localparam int SLOT_W   = 6;
  localparam int PORTS    = 3;
  localparam int SIG_W    = 16;
  localparam int LOG_W    = 8;
  localparam int LOG_DEPTH = 4;

  // Instruction codes (values of our own choosing).
  localparam logic [7:0] I_BYPASS     = 8'hFF;
  localparam logic [7:0] I_MODE_SEL   = 8'h8E;
  localparam logic [7:0] I_UNPARK     = 8'hE2;
  localparam logic [7:0] I_PARK_RESET = 8'hC5;
  localparam logic [7:0] I_PARK_IDLE  = 8'h84;
  localparam logic [7:0] I_RET_WAIT   = 8'hC3;
  localparam logic [7:0] I_GROUP_SEL  = 8'h03;
  localparam logic [7:0] I_SIG_EN     = 8'h0F;
  localparam logic [7:0] I_SIG_SEL    = 8'h0C;
  localparam logic [7:0] I_SOFT_RST   = 8'h88;

  // Addressing.
  localparam logic [7:0] ADDR_BROADCAST = 8'h3B;
  localparam logic [5:0] ADDR_MCAST_TOP = 6'h0F;
  localparam logic [1:0] ADDR_PAD       = 2'h0;
  localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;

  // Reset values and data register top indices.
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam logic [7:0]  MODE_ALL_SERIAL = 8'h07;
  localparam logic [1:0]  GROUP_RESET     = 2'h0;
  localparam logic [15:0] SIG_RESET       = 16'h0000;
  localparam logic [15:0] SIG_POLY        = 16'hB400;
  localparam logic [3:0]  TOP_BYPASS      = 4'h0;
  localparam logic [3:0]  TOP_MODE        = 4'h7;
  localparam logic [3:0]  TOP_GROUP       = 4'h1;
  localparam logic [3:0]  TOP_SIG         = 4'hF;
  localparam logic [2:0]  SOFT_RESET_TCKS = 3'h5;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } msb_tap_t;
  typedef enum logic [2:0] {SEL_WAIT, SEL_ONE, SEL_MCAST, SEL_BCAST, SEL_NONE} msb_sel_t;
  typedef enum logic [1:0] {PARK_RESET, PARK_IDLE, PORT_LIVE} msb_park_t;
endpackage

// File: core/msb_bridge.sv
// Scan bridge control: backplane TAP, selection, local port parking and log FIFO.
// How it works
// - An unpark request waits until the bridge TAP sits in Run-Test/Idle, then splices the ports enabled in the mode register into the chain.
// - Mode value 00000111 joins all three local ports in series, port 0 first.
// - The mode register keeps its value across deselection and is cleared only in Test-Logic-Reset.
// - The return-to-wait instruction parks every local port in reset and sends selection back to wait-for-address.
// - The park-in-reset instruction holds all three local mode-select outputs high.
// - The group-select instruction puts the two-bit multicast group register into the data path.
// - Multicast address 00111101 selects every bridge whose group register holds 01.
// - The signature-enable instruction starts signature compaction in any selected bridge, multicast included.
// - The signature-select instruction puts the signature register into the data path for readout.
// - The park-in-idle instruction holds live ports in Run-Test/Idle so their instructions stay active.
// - Broadcast address 3B selects every bridge whatever its slot.
// - The soft reset instruction drives all local mode-select outputs high and parks every local port in reset, so they stay high until the next unpark.
// - The bridge's bypass instruction gives a single stage while local chains are in the path.
// - Capture-IR loads 01 into the two low instruction bits and the slot levels above them.
// - At Update-IR in wait, a slot, broadcast or own-group multicast match selects this bridge; any other code leaves it unselected.
`timescale 1ns/1ps

module msb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  // Fill side.
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // Drain side.
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;

  // Full and empty come straight from the occupancy count.
  assign in_ready_out  = (count < (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];

  // Pointers wrap at the depth so a non-power-of-two depth still works.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage has no reset; only written slots are ever presented.
  always_ff @(posedge clk_sys_in) begin
    if (push) mem[wr_ptr] <= in_data_in;
  end
endmodule

module msb_bridge (
  // System clock and reset.
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // Backplane test port.
  input  wire logic       bp_clk_in,
  input  wire logic       bp_mode_in,
  input  wire logic       bp_data_in,
  output logic            bp_data_out,
  output logic            bp_data_oe_out,
  input  wire logic [5:0] slot_in,
  // Local scan ports.
  output logic            local_clk_out,
  output logic [2:0]      local_mode_select_out,
  output logic [2:0]      local_data_out,
  input  wire logic [2:0] local_data_in,
  // Instruction log stream.
  output logic [7:0]      log_data_out,
  output logic            log_valid_out,
  input  wire logic       log_ready_in,
  output logic            log_space_out
);
  localparam int NP = msb_pkg::PORTS;
  localparam int SW = 3 + msb_pkg::SLOT_W + NP;

  logic [SW-1:0]     pin_meta;
  logic [SW-1:0]     pin_sync;
  logic              clk_q;
  msb_pkg::msb_tap_t tap;
  msb_pkg::msb_tap_t next_tap;
  msb_pkg::msb_sel_t sel;
  msb_pkg::msb_park_t park [NP];
  logic [7:0]        ir_sh;
  logic [7:0]        instr;
  logic [15:0]       dr_sh;
  logic [15:0]       next_dr;
  logic [15:0]       cap_dr;
  logic [3:0]        dr_top;
  logic [7:0]        mode;
  logic [1:0]        group;
  logic [15:0]       sig;
  logic              sig_on;
  logic              unpark_pend;
  logic [2:0]        soft_cnt;
  logic [NP:0]       stage;
  logic [NP-1:0]     live_mask;
  logic [NP-1:0]     next_local_mode;

  // Every pin passes two flops; only the second stage feeds logic.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
      clk_q    <= 1'b0;
    end else begin
      pin_meta <= {bp_clk_in, bp_mode_in, bp_data_in, slot_in, local_data_in};
      pin_sync <= pin_meta;
      clk_q    <= pin_sync[SW-1];
    end
  end

  wire             tck_s    = pin_sync[SW-1];
  wire             tms_s    = pin_sync[SW-2];
  wire             tdi_s    = pin_sync[SW-3];
  wire [5:0]       slot_s   = pin_sync[NP +: msb_pkg::SLOT_W];
  wire [NP-1:0]    ret_s    = pin_sync[NP-1:0];
  wire             tck_rise = tck_s && !clk_q;
  wire             tck_fall = !tck_s && clk_q;
  wire             sel_any  = (sel == msb_pkg::SEL_ONE) || (sel == msb_pkg::SEL_MCAST) ||
                              (sel == msb_pkg::SEL_BCAST);
  wire             upd_ir   = tck_rise && (tap == msb_pkg::TAP_UPD_IR);
  wire             upd_dr   = tck_rise && (tap == msb_pkg::TAP_UPD_DR) && sel_any;
  wire             chain_tail = stage[NP];
  wire             soft_on  = (soft_cnt != 3'h0);
  wire             sig_fb   = sig[15] ^ chain_tail;
  wire [15:0]      sig_step = {sig[14:0], 1'b0} ^ (sig_fb ? msb_pkg::SIG_POLY : 16'h0000);
  wire             is_bcast = (ir_sh == msb_pkg::ADDR_BROADCAST);
  wire             is_mcast = (ir_sh[7:2] == msb_pkg::ADDR_MCAST_TOP) && (ir_sh[1:0] == group);
  wire             is_slot  = (ir_sh == {msb_pkg::ADDR_PAD, slot_s});

  // Live ports are spliced in series, lowest port nearest the backplane input.
  assign stage[0] = tdi_s;
  for (genvar n = 0; n < NP; n++) begin : g_port
    assign live_mask[n]       = (park[n] == msb_pkg::PORT_LIVE);
    assign stage[n+1]         = live_mask[n] ? ret_s[n] : stage[n];
    assign next_local_mode[n] = (soft_on || park[n] == msb_pkg::PARK_RESET) ? 1'b1 :
                                (park[n] == msb_pkg::PARK_IDLE) ? 1'b0 : tms_s;
  end

  // Standard TAP sequencing on each backplane clock rise.
  always_comb begin
    case (tap)
      msb_pkg::TAP_RESET:  next_tap = tms_s ? msb_pkg::TAP_RESET  : msb_pkg::TAP_IDLE;
      msb_pkg::TAP_IDLE:   next_tap = tms_s ? msb_pkg::TAP_SEL_DR : msb_pkg::TAP_IDLE;
      msb_pkg::TAP_SEL_DR: next_tap = tms_s ? msb_pkg::TAP_SEL_IR : msb_pkg::TAP_CAP_DR;
      msb_pkg::TAP_CAP_DR: next_tap = tms_s ? msb_pkg::TAP_EX1_DR : msb_pkg::TAP_SH_DR;
      msb_pkg::TAP_SH_DR:  next_tap = tms_s ? msb_pkg::TAP_EX1_DR : msb_pkg::TAP_SH_DR;
      msb_pkg::TAP_EX1_DR: next_tap = tms_s ? msb_pkg::TAP_UPD_DR : msb_pkg::TAP_PA_DR;
      msb_pkg::TAP_PA_DR:  next_tap = tms_s ? msb_pkg::TAP_EX2_DR : msb_pkg::TAP_PA_DR;
      msb_pkg::TAP_EX2_DR: next_tap = tms_s ? msb_pkg::TAP_UPD_DR : msb_pkg::TAP_SH_DR;
      msb_pkg::TAP_UPD_DR: next_tap = tms_s ? msb_pkg::TAP_SEL_DR : msb_pkg::TAP_IDLE;
      msb_pkg::TAP_SEL_IR: next_tap = tms_s ? msb_pkg::TAP_RESET  : msb_pkg::TAP_CAP_IR;
      msb_pkg::TAP_CAP_IR: next_tap = tms_s ? msb_pkg::TAP_EX1_IR : msb_pkg::TAP_SH_IR;
      msb_pkg::TAP_SH_IR:  next_tap = tms_s ? msb_pkg::TAP_EX1_IR : msb_pkg::TAP_SH_IR;
      msb_pkg::TAP_EX1_IR: next_tap = tms_s ? msb_pkg::TAP_UPD_IR : msb_pkg::TAP_PA_IR;
      msb_pkg::TAP_PA_IR:  next_tap = tms_s ? msb_pkg::TAP_EX2_IR : msb_pkg::TAP_PA_IR;
      msb_pkg::TAP_EX2_IR: next_tap = tms_s ? msb_pkg::TAP_UPD_IR : msb_pkg::TAP_SH_IR;
      msb_pkg::TAP_UPD_IR: next_tap = tms_s ? msb_pkg::TAP_SEL_DR : msb_pkg::TAP_IDLE;
      default:             next_tap = msb_pkg::TAP_RESET;
    endcase
  end

  // The active instruction picks the data register length and its capture value.
  always_comb begin
    case (instr)
      msb_pkg::I_MODE_SEL:  dr_top = msb_pkg::TOP_MODE;
      msb_pkg::I_GROUP_SEL: dr_top = msb_pkg::TOP_GROUP;
      msb_pkg::I_SIG_SEL:   dr_top = msb_pkg::TOP_SIG;
      default:              dr_top = msb_pkg::TOP_BYPASS;
    endcase
    case (instr)
      msb_pkg::I_MODE_SEL:  cap_dr = {8'h00, mode};
      msb_pkg::I_GROUP_SEL: cap_dr = {14'h0000, group};
      msb_pkg::I_SIG_SEL:   cap_dr = sig;
      default:              cap_dr = 16'h0000;
    endcase
    next_dr         = dr_sh >> 1;
    next_dr[dr_top] = chain_tail;
  end

  // Scan registers shift in every bridge so that addressing reaches all of them.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tap   <= msb_pkg::TAP_RESET;
      ir_sh <= msb_pkg::I_BYPASS;
      dr_sh <= 16'h0000;
    end else if (tck_rise) begin
      tap <= next_tap;
      if (tap == msb_pkg::TAP_CAP_IR) ir_sh <= {slot_s, msb_pkg::IR_CAPTURE_LOW};
      if (tap == msb_pkg::TAP_SH_IR) ir_sh <= {chain_tail, ir_sh[7:1]};
      if (tap == msb_pkg::TAP_CAP_DR) dr_sh <= cap_dr;
      if (tap == msb_pkg::TAP_SH_DR) dr_sh <= next_dr;
    end
  end

  // Selection, instruction execution and port parking.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel         <= msb_pkg::SEL_WAIT;
      instr       <= msb_pkg::I_BYPASS;
      mode        <= msb_pkg::MODE_RESET;
      group       <= msb_pkg::GROUP_RESET;
      sig         <= msb_pkg::SIG_RESET;
      sig_on      <= 1'b0;
      unpark_pend <= 1'b0;
      soft_cnt    <= 3'h0;
      for (int n = 0; n < NP; n++) park[n] <= msb_pkg::PARK_RESET;
    end else if (tck_rise) begin
      if (soft_on) soft_cnt <= soft_cnt - 3'h1;
      if (tap == msb_pkg::TAP_RESET) begin
        sel         <= msb_pkg::SEL_WAIT;
        instr       <= msb_pkg::I_BYPASS;
        mode        <= msb_pkg::MODE_RESET;
        group       <= msb_pkg::GROUP_RESET;
        sig_on      <= 1'b0;
        unpark_pend <= 1'b0;
        for (int n = 0; n < NP; n++) park[n] <= msb_pkg::PARK_RESET;
      end else if (upd_ir && ir_sh == msb_pkg::I_RET_WAIT) begin
        sel         <= msb_pkg::SEL_WAIT;
        instr       <= msb_pkg::I_BYPASS;
        unpark_pend <= 1'b0;
        for (int n = 0; n < NP; n++) park[n] <= msb_pkg::PARK_RESET;
      end else if (upd_ir && sel == msb_pkg::SEL_WAIT) begin
        instr <= msb_pkg::I_BYPASS;
        if (is_bcast) sel <= msb_pkg::SEL_BCAST;
        else if (is_mcast) sel <= msb_pkg::SEL_MCAST;
        else if (is_slot) sel <= msb_pkg::SEL_ONE;
        else sel <= msb_pkg::SEL_NONE;
      end else if (upd_ir && sel_any) begin
        instr <= ir_sh;
        case (ir_sh)
          msb_pkg::I_UNPARK:  unpark_pend <= 1'b1;
          msb_pkg::I_SIG_EN:  sig_on <= 1'b1;
          msb_pkg::I_SOFT_RST: begin
            soft_cnt <= msb_pkg::SOFT_RESET_TCKS;
            for (int n = 0; n < NP; n++) park[n] <= msb_pkg::PARK_RESET;
          end
          msb_pkg::I_PARK_RESET: begin
            for (int n = 0; n < NP; n++) park[n] <= msb_pkg::PARK_RESET;
          end
          msb_pkg::I_PARK_IDLE: begin
            for (int n = 0; n < NP; n++) begin
              if (live_mask[n]) park[n] <= msb_pkg::PARK_IDLE;
            end
          end
          default: ;
        endcase
      end else begin
        // Unpark waits for Run-Test/Idle so bridge and local TAPs move in step.
        if (unpark_pend && tap == msb_pkg::TAP_IDLE) begin
          unpark_pend <= 1'b0;
          for (int n = 0; n < NP; n++) begin
            park[n] <= mode[n] ? msb_pkg::PORT_LIVE : park[n];
          end
        end
        if (upd_dr && instr == msb_pkg::I_MODE_SEL) mode <= dr_sh[7:0];
        if (upd_dr && instr == msb_pkg::I_GROUP_SEL) group <= dr_sh[1:0];
        if (sig_on && tap == msb_pkg::TAP_SH_DR) sig <= sig_step;
      end
    end
  end

  // Outputs are registered; the backplane answer changes on the falling test clock.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bp_data_out           <= 1'b1;
      bp_data_oe_out        <= 1'b0;
      local_clk_out         <= 1'b0;
      local_mode_select_out <= 3'h7;
      local_data_out        <= 3'h0;
    end else begin
      local_clk_out         <= tck_s;
      local_mode_select_out <= next_local_mode;
      local_data_out        <= stage[NP-1:0];
      if (tck_fall) begin
        bp_data_out    <= (tap == msb_pkg::TAP_SH_IR) ? ir_sh[0] : dr_sh[0];
        bp_data_oe_out <= (sel == msb_pkg::SEL_ONE) &&
                          (tap == msb_pkg::TAP_SH_IR || tap == msb_pkg::TAP_SH_DR);
      end
    end
  end

  // Each instruction updated while this bridge is selected is logged; a full log drops words, shown by log_space_out.
  msb_fifo #(.WIDTH(msb_pkg::LOG_W), .DEPTH(msb_pkg::LOG_DEPTH)) u_log (
    .clk_sys_in   (clk_sys_in),
    .rst_n_in     (rst_n_in),
    .in_data_in   (ir_sh),
    .in_valid_in  (upd_ir && sel_any),
    .in_ready_out (log_space_out),
    .out_data_out (log_data_out),
    .out_valid_out(log_valid_out),
    .out_ready_in (log_ready_in)
  );

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_upd_ir(logic [7:0] code);
    upd_ir && ir_sh == code;
  endsequence
  sequence s_wait_upd;
    upd_ir && sel == msb_pkg::SEL_WAIT && tap == msb_pkg::TAP_UPD_IR;
  endsequence

  property p_unpark_sync;
    tck_rise && tap == msb_pkg::TAP_IDLE && unpark_pend && !upd_ir |=>
      (live_mask & $past(mode[2:0])) == $past(mode[2:0]);
  endproperty
  a_unpark_sync: assert property (p_unpark_sync) else $error("unpark not applied");
  property p_all_serial;
    live_mask == msb_pkg::MODE_ALL_SERIAL[2:0] |->
      chain_tail == ret_s[2] ##1 local_data_out == $past({ret_s[1:0], tdi_s});
  endproperty
  a_all_serial: assert property (p_all_serial) else $error("ports not in series");
  property p_mode_keep;
    $changed(mode) |-> $past(tap) == msb_pkg::TAP_RESET || $past(upd_dr);
  endproperty
  a_mode_keep: assert property (p_mode_keep) else $error("mode changed wrongly");
  property p_ret_wait;
    s_upd_ir(msb_pkg::I_RET_WAIT) |=> sel == msb_pkg::SEL_WAIT && live_mask == 3'h0;
  endproperty
  a_ret_wait: assert property (p_ret_wait) else $error("return to wait failed");
  property p_park_high;
    s_upd_ir(msb_pkg::I_PARK_RESET) ##0 sel_any |=> ##1 local_mode_select_out == 3'h7;
  endproperty
  a_park_high: assert property (p_park_high) else $error("park reset not high");
  property p_group_load;
    upd_dr && instr == msb_pkg::I_GROUP_SEL |=> group == $past(dr_sh[1:0]);
  endproperty
  a_group_load: assert property (p_group_load) else $error("group not loaded");
  property p_mcast;
    s_wait_upd ##0 (!is_bcast && is_mcast) |=> sel == msb_pkg::SEL_MCAST;
  endproperty
  a_mcast: assert property (p_mcast) else $error("multicast not selected");
  property p_sig_on;
    s_upd_ir(msb_pkg::I_SIG_EN) ##0 sel_any |=> sig_on;
  endproperty
  a_sig_on: assert property (p_sig_on) else $error("signature not enabled");
  property p_bcast;
    s_wait_upd ##0 is_bcast |=> sel == msb_pkg::SEL_BCAST;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast not selected");
  property p_soft;
    s_upd_ir(msb_pkg::I_SOFT_RST) ##0 sel_any |=> ##1 (local_mode_select_out == 3'h7) [*8];
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset not held high");
  property p_capture;
    tck_rise && tap == msb_pkg::TAP_CAP_IR |=>
      ir_sh == {$past(slot_s), msb_pkg::IR_CAPTURE_LOW};
  endproperty
  a_capture: assert property (p_capture) else $error("bad IR capture");
  property p_slot_sel;
    s_wait_upd ##0 (!is_bcast && !is_mcast) |=> (sel == msb_pkg::SEL_ONE) == $past(is_slot);
  endproperty
  a_slot_sel: assert property (p_slot_sel) else $error("slot selection wrong");
endmodule

// File: sim/msb_master.sv
// Behavioural backplane test master that drives the bridge test port.
`timescale 1ns/1ps

module msb_master (
  // Test port toward the bridge.
  output logic      bp_clk_out,
  output logic      bp_mode_out,
  output logic      bp_data_out,
  // Return line from the bridge.
  input  wire logic tdo_in,
  input  wire logic tdo_oe_in
);
  // The return line has a pull-up, so an undriven line reads high.
  wire logic tdo_line;
  assign tdo_line = tdo_oe_in ? tdo_in : 1'b1;

  // Test clock stands low and data idles high outside frames.
  initial begin
    bp_clk_out = 1'b0;
    bp_mode_out = 1'b1;
    bp_data_out = 1'b1;
  end

  // One 48 ns test clock; the return bit is read just before the fall, where it is settled.
  task automatic tck(input logic tms, input logic tdi, output logic tdo);
    bp_mode_out <= tms;
    bp_data_out <= tdi;
    #24 bp_clk_out <= 1'b1;
    #23 tdo = tdo_line;
    #1 bp_clk_out <= 1'b0;
  endtask

  // Five clocks with mode high reach Test-Logic-Reset, then settle in Run-Test/Idle.
  task automatic reset_tap();
    logic d;
    repeat (5) tck(1'b1, 1'b1, d);
    tck(1'b0, 1'b1, d);
  endtask

  // Full scan from Run-Test/Idle back to Run-Test/Idle, least significant bit first.
  task automatic scan(input logic ir, input logic [15:0] data, input int n,
                      output logic [15:0] cap);
    logic d;
    cap = 16'h0000;
    tck(1'b1, 1'b1, d);
    if (ir) begin
      tck(1'b1, 1'b1, d);
    end
    tck(1'b0, 1'b1, d);
    tck(1'b0, 1'b1, d);
    for (int i = 0; i < n; i++) begin
      tck(i == n - 1, data[i], d);
      cap[i] = d;
    end
    tck(1'b1, 1'b1, d);
    tck(1'b0, 1'b1, d);
  endtask
endmodule

// File: sim/multidrop_scan_bridge_control_test.sv
// Self-checking bench for the scan bridge control block.
`timescale 1ns/1ps

module multidrop_scan_bridge_control_test;
  localparam logic [5:0] SLOT = 6'h05;
  logic        clk_sys_in;
  logic        rst_n_in;
  logic [5:0]  slot_in;
  logic        log_ready_in;
  logic        d;
  logic [15:0] cap;
  int          bad_count;
  int          n_checks;
  wire logic   bp_clk, bp_mode, bp_din, bp_dout, bp_oe, log_valid, log_space;
  wire logic [2:0] lms, ldo, ldi;
  wire logic [7:0] log_data;

  wire logic       lclk;
  logic            lclk_d = 1'b0;
  logic [2:0]      port_q = 3'h0;

  // Each local port acts as one bypass stage on the local test clock, so a live port adds
  // one bit to every scan; its edge is found on the system clock to stay clear of races.
  always @(posedge clk_sys_in) begin
    lclk_d <= lclk;
    if (lclk && !lclk_d) port_q <= ldo;
  end
  assign ldi = port_q;

  msb_master m (.bp_clk_out(bp_clk), .bp_mode_out(bp_mode), .bp_data_out(bp_din),
                .tdo_in(bp_dout), .tdo_oe_in(bp_oe));

  msb_bridge uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .bp_clk_in(bp_clk),
    .bp_mode_in(bp_mode), .bp_data_in(bp_din), .bp_data_out(bp_dout),
    .bp_data_oe_out(bp_oe), .slot_in(slot_in), .local_clk_out(lclk),
    .local_mode_select_out(lms), .local_data_out(ldo), .local_data_in(ldi),
    .log_data_out(log_data), .log_valid_out(log_valid), .log_ready_in(log_ready_in),
    .log_space_out(log_space));

  // System clock at 200 MHz.
  initial clk_sys_in = 1'b0;
  always #2.5 clk_sys_in = ~clk_sys_in;

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic ir(input logic [7:0] code);
    m.scan(1'b1, {8'h00, code}, 8, cap);
  endtask

  // With all three ports live, three port stages follow the bridge instruction bits.
  task automatic ir_live(input logic [7:0] code);
    m.scan(1'b1, {8'h07, code}, 11, cap);
  endtask

  task automatic dr(input logic [15:0] v, input int n);
    m.scan(1'b0, v, n, cap);
  endtask

  // Local ports need test clocks in Run-Test/Idle before they join the chain.
  task automatic settle();
    m.tck(1'b0, 1'b1, d);
    m.tck(1'b0, 1'b1, d);
  endtask

  // Holds the backplane mode level with the test clock still, then reads the local levels.
  task automatic lms_at(input logic tms, input logic [2:0] exp);
    @(posedge clk_sys_in);
    m.bp_mode_out <= tms;
    repeat (8) @(posedge clk_sys_in);
    check("local mode select", {13'h0, exp}, {13'h0, lms});
  endtask

  task automatic t_log();
    logic [7:0] codes [5];
    codes = '{msb_pkg::I_BYPASS, msb_pkg::I_MODE_SEL, msb_pkg::I_SIG_SEL,
              msb_pkg::I_GROUP_SEL, msb_pkg::I_BYPASS};
    m.reset_tap();
    ir({2'b00, SLOT});
    foreach (codes[i]) begin
      ir(codes[i]);
      check("ir capture", {8'h00, SLOT, 2'b01}, cap);
    end
    check("log space", 16'h0000, {15'h0, log_space});
    @(posedge clk_sys_in);
    log_ready_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys_in);
      check("log word", {8'h01, codes[i]}, {7'h0, log_valid, log_data});
      @(posedge clk_sys_in);
    end
    @(negedge clk_sys_in);
    check("log valid", 16'h0000, {15'h0, log_valid});
  endtask

  task automatic t_unpark();
    ir(msb_pkg::I_MODE_SEL);
    dr({8'h00, msb_pkg::MODE_ALL_SERIAL}, 8);
    ir(msb_pkg::I_UNPARK);
    settle();
    lms_at(1'b1, 3'h7);
    lms_at(1'b0, 3'h0);
  endtask

  task automatic t_retain();
    ir_live(msb_pkg::I_RET_WAIT);
    lms_at(1'b0, 3'h7);
    ir({2'b00, SLOT});
    check("wait readback", 16'h00FF, cap);
    ir(msb_pkg::I_MODE_SEL);
    dr(16'h0007, 8);
    check("kept mode", 16'h0007, cap);
    ir(msb_pkg::I_UNPARK);
    settle();
    lms_at(1'b1, 3'h7);
  endtask

  task automatic t_park();
    ir_live(msb_pkg::I_PARK_IDLE);
    lms_at(1'b1, 3'h0);
    ir(msb_pkg::I_PARK_RESET);
    lms_at(1'b0, 3'h7);
  endtask

  task automatic t_bcast();
    ir(msb_pkg::I_RET_WAIT);
    ir({2'b00, SLOT + 6'h01});
    ir(msb_pkg::I_RET_WAIT);
    check("unselected readback", 16'h00FF, cap);
    ir(msb_pkg::ADDR_BROADCAST);
    ir(msb_pkg::I_UNPARK);
    settle();
    lms_at(1'b0, 3'h0);
    ir_live(msb_pkg::I_SOFT_RST);
    for (int i = 0; i < 5; i++) begin
      m.tck(1'b0, 1'b1, d);
      check("soft reset level", 16'h0007, {13'h0, lms});
    end
  endtask

  task automatic t_treset_mcast();
    m.reset_tap();
    ir({2'b00, SLOT});
    ir(msb_pkg::I_MODE_SEL);
    dr(16'h0000, 8);
    check("mode after reset", 16'h0000, cap);
    ir(msb_pkg::I_GROUP_SEL);
    dr(16'h0001, 2);
    ir(msb_pkg::I_RET_WAIT);
    ir(8'h3D);
    ir(msb_pkg::I_SIG_EN);
    dr(16'hA5C3, 16);
    ir(msb_pkg::I_RET_WAIT);
    ir({2'b00, SLOT});
    ir(msb_pkg::I_SIG_SEL);
    dr(16'h0000, 16);
    n_checks++;
    if (cap === msb_pkg::SIG_RESET || $isunknown(cap)) begin
      bad_count++;
      $display("unexpected signature: expected nonzero, seen %h", cap);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // The sequence needs well under 100 us of test clocks.
  initial begin
    #300000;
    bad_count++;
    $display("unexpected watchdog expiry");
    wrap_up();
  end

  initial begin
    rst_n_in = 1'b0;
    slot_in = SLOT;
    log_ready_in = 1'b0;
    repeat (12) @(posedge clk_sys_in);
    check("reset level", 16'h0007, {13'h0, lms});
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    t_log();
    t_unpark();
    t_retain();
    t_park();
    t_bcast();
    t_treset_mcast();
    wrap_up();
  end
endmodule
